// File: capreq_regs.vh
// register offsets, field positions, reset values and sizes of the capacity requester
// assumes a 32-bit avalon-mm slave with byte addresses, one aligned word per register
`ifndef CAPREQ_REGS_VH
`define CAPREQ_REGS_VH

// register byte offsets
`define OFS_CTRL        6'h00
`define OFS_MSL         6'h04
`define OFS_RATE_MAX    6'h08
`define OFS_CRA         6'h0C
`define OFS_PHYS_MAX    6'h10
`define OFS_ALLOW_MAX   6'h14
`define OFS_TIMEOUT     6'h18
`define OFS_VOL_MAX     6'h1C
`define OFS_NM_CELLS    6'h20
`define OFS_STAT_RATE   6'h24
`define OFS_STAT_PEND   6'h28
`define OFS_STAT_Q01    6'h2C
`define OFS_STAT_Q23    6'h30

// control field positions
`define CTRL_ENABLE     0
`define CTRL_PAD_EMPTY  1
`define CTRL_DUP_RATE   2
`define CTRL_ABSOLUTE   3

// reset values
`define RST_CTRL        4'h2
`define RST_MSL         4'h4
`define RST_RATE_MAX    16'h0000
`define RST_CRA         16'h0001
`define RST_PHYS_MAX    16'h0100
`define RST_ALLOW_MAX   16'h0100
`define RST_TIMEOUT     8'h10
`define RST_VOL_MAX     16'h0040
`define RST_NM_CELLS    16'h0000

// sizes
`define CW              16
`define HIST_DEPTH      16
`define NQ              4

// queue indices in service order
`define Q_FIXED         2'h0
`define Q_VAR_RT        2'h1
`define Q_VAR_JT        2'h2
`define Q_JT            2'h3

// request kinds on the request port
`define KIND_RATE       2'h0
`define KIND_VOLUME     2'h1
`define KIND_ABS_VOLUME 2'h2

`endif

// File: return_capacity_requester.v
// return-channel capacity requester: queue tracking, per-frame request computation,
// request sequencing onto the opportunities of each frame, avalon-mm register slave.
// assumes frame tick, assignment and arrivals come from logic on I_CLK.
//
// The implementer's own choices: the Avalon-MM register port and the register addresses.
`include "capreq_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module return_capacity_requester (
    input  wire        I_CLK,            // 25 mhz system clock
    input  wire        I_RESET_N,        // async reset, active low
    input  wire [5:0]  i_avs_address,    // byte address
    input  wire        i_avs_read,       // read request
    input  wire        i_avs_write,      // write request
    input  wire [3:0]  i_avs_byteenable, // byte lanes of write
    input  wire [31:0] i_avs_writedata,  // write data
    output reg  [31:0] o_avs_readdata,   // read data
    output wire        o_avs_waitrequest,// stall until answer
    input  wire        i_frame_tick,     // one pulse per frame, assignment valid
    input  wire [15:0] i_assign_cells,   // aggregate assignment of this frame
    input  wire [1:0]  i_cr_slots,       // request opportunities this frame
    input  wire        i_arr_valid,      // cells arrived
    input  wire [1:0]  i_arr_class,      // queue of arrival
    input  wire [7:0]  i_arr_cells,      // cells arrived
    output wire        o_cr_valid,       // request offered
    output reg  [1:0]  o_cr_kind,        // rate, volume or absolute
    output reg  [15:0] o_cr_value,       // request size in cells
    input  wire        i_cr_ready,       // request taken
    output wire        o_pad_empty,      // transmit in empty slots
    output reg  [15:0] o_q_fixed,        // fixed-rate queue level
    output reg  [15:0] o_q_var_rt,       // jitter-sensitive queue level
    output reg  [15:0] o_q_var_jt,       // jitter-tolerant variable queue level
    output reg  [15:0] o_q_jt            // jitter-tolerant queue level
);

    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_CALC  = 3'h1;
    localparam [2:0] ST_RATE  = 3'h2;
    localparam [2:0] ST_RATE2 = 3'h3;
    localparam [2:0] ST_VOL   = 3'h4;

    // configuration registers
    reg  [3:0]   ctrl_q;
    reg  [3:0]   msl_q;
    reg  [15:0]  rate_max_q;
    reg  [15:0]  cra_q;
    reg  [15:0]  phys_max_q;
    reg  [15:0]  allow_max_q;
    reg  [7:0]   timeout_q;
    reg  [15:0]  vol_max_q;
    reg  [15:0]  nm_cells_q;
    reg          ack_q;

    // block state
    reg  [15:0]  q_q [0:`NQ-1];
    reg  [15:0]  take [0:`NQ-1];
    reg  [15:0]  hist_q [0:`HIST_DEPTH-1];
    reg  [15:0]  rt_arr_q;               // sensitive arrivals this frame
    reg  [15:0]  rt_prev_q;              // sensitive arrivals last frame
    reg  [15:0]  pend_jt_q;
    reg  [15:0]  last_rate_q;
    reg  [15:0]  vrjt_q;                 // tolerant part of active request
    reg  [7:0]   since_q;
    reg  [15:0]  vr_req_q;
    reg          send_rate_q;
    reg  [15:0]  vrem_q;
    reg  [1:0]   opp_q;
    reg  [2:0]   st_q;

    // combinational request values
    reg  [15:0]  left;
    reg  [15:0]  limit;
    reg  [15:0]  vrrt_c;
    reg  [15:0]  vrjt_c;
    reg  [15:0]  pend_vr;
    reg  [16:0]  vr_sum;
    reg  [15:0]  vr_tot;
    reg  [15:0]  jt_c;
    reg  [16:0]  jt_sum;
    reg  [17:0]  used;
    reg  [15:0]  room;
    reg  [15:0]  jt_tot;
    reg  [15:0]  chunk;
    reg  [31:0]  reg_word;               // addressed register, zero-extended; status words packed
    integer      k;
    integer      m;

    wire         take_cr = o_cr_valid & i_cr_ready;
    wire         bus_req = i_avs_read | i_avs_write;
    wire [31:0]  wmask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                          {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
    wire [31:0]  new_word;               // addressed register after byte merge
    wire [15:0]  vrjt_new;               // tolerant part left active after this frame

    // merge written byte lanes into the old value
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [31:0] m;
        begin
            merge = (old & ~m) | (nw & m);
        end
    endfunction

    // one merge path for all writes, so every field is cut from one word
    assign new_word = merge(reg_word, i_avs_writedata, wmask);
    assign vrjt_new = (rate_max_q != 16'h0000) ? vrjt_c : vrjt_q;

    // one-cycle wait state keeps readdata registered
    assign o_avs_waitrequest = bus_req & ~ack_q;
    assign o_pad_empty = ctrl_q[`CTRL_PAD_EMPTY];
    // rate states offer only while a rate request is due, never a stale value
    assign o_cr_valid = ((((st_q == ST_RATE) || (st_q == ST_RATE2)) && send_rate_q) ||
                         ((st_q == ST_VOL) && (vrem_q != 16'h0000))) && (opp_q != 2'h0);

    // aggregate assignment spread over queues in priority order
    always @* begin
        left = i_assign_cells;
        for (k = 0; k < `NQ; k = k + 1) begin
            take[k] = (q_q[k] < left) ? q_q[k] : left;
            left = left - take[k];
        end
    end

    // per-frame request components, from queues after this frame's assignment
    always @* begin
        limit = (phys_max_q < allow_max_q) ? phys_max_q : allow_max_q;
        vrrt_c = (rt_prev_q > cra_q) ? rt_prev_q - cra_q : 16'h0000;
        pend_vr = 16'h0000;
        for (m = 0; m < `HIST_DEPTH; m = m + 1) begin
            if (m < msl_q) begin
                pend_vr = pend_vr + hist_q[m];
            end
        end
        vrjt_c = (q_q[`Q_VAR_JT] > pend_vr) ? q_q[`Q_VAR_JT] - pend_vr : 16'h0000;
        vr_sum = {1'b0, vrrt_c} + {1'b0, vrjt_c};
        vr_tot = (vr_sum > {1'b0, rate_max_q}) ? rate_max_q : vr_sum[15:0];
        if ({1'b0, cra_q} + {1'b0, vr_tot} > {1'b0, limit}) begin
            vr_tot = (limit > cra_q) ? limit - cra_q : 16'h0000;
        end
        jt_c = (q_q[`Q_JT] > pend_jt_q) ? q_q[`Q_JT] - pend_jt_q : 16'h0000;
        jt_sum = {1'b0, jt_c} + {1'b0, nm_cells_q};
        used = {2'h0, cra_q} + {2'h0, vr_tot} + {2'h0, pend_jt_q};
        room = (used < {2'h0, limit}) ? limit - used[15:0] : 16'h0000;
        jt_tot = (jt_sum > {1'b0, room}) ? room : jt_sum[15:0];
        chunk = (vrem_q > vol_max_q) ? vol_max_q : vrem_q;
    end

    // addressed register word, shared by read data and the write merge
    always @* begin
        case ({i_avs_address[5:2], 2'h0})
            `OFS_CTRL:      reg_word = {28'h0, ctrl_q};
            `OFS_MSL:       reg_word = {28'h0, msl_q};
            `OFS_RATE_MAX:  reg_word = {16'h0, rate_max_q};
            `OFS_CRA:       reg_word = {16'h0, cra_q};
            `OFS_PHYS_MAX:  reg_word = {16'h0, phys_max_q};
            `OFS_ALLOW_MAX: reg_word = {16'h0, allow_max_q};
            `OFS_TIMEOUT:   reg_word = {24'h0, timeout_q};
            `OFS_VOL_MAX:   reg_word = {16'h0, vol_max_q};
            `OFS_NM_CELLS:  reg_word = {16'h0, nm_cells_q};
            `OFS_STAT_RATE: reg_word = {since_q, 8'h0, last_rate_q};
            `OFS_STAT_PEND: reg_word = {13'h0, st_q, pend_jt_q};
            `OFS_STAT_Q01:  reg_word = {q_q[`Q_VAR_RT], q_q[`Q_FIXED]};
            `OFS_STAT_Q23:  reg_word = {q_q[`Q_JT], q_q[`Q_VAR_JT]};
            default:        reg_word = 32'h00000000;
        endcase
    end

    // queue level per class, arrivals in and assignment out
    genvar g;
    generate
        for (g = 0; g < `NQ; g = g + 1) begin : g_queue
            always @(posedge I_CLK or negedge I_RESET_N) begin
                if (!I_RESET_N) begin
                    q_q[g] <= 16'h0000;
                end else begin
                    q_q[g] <= q_q[g]
                        + ((i_arr_valid && i_arr_class == g) ? {8'h00, i_arr_cells} : 16'h0000)
                        - (i_frame_tick ? take[g] : 16'h0000);
                end
            end
        end
        // history of the tolerant variable request left active each frame
        for (g = 0; g < `HIST_DEPTH; g = g + 1) begin : g_hist
            always @(posedge I_CLK or negedge I_RESET_N) begin
                if (!I_RESET_N) begin
                    hist_q[g] <= 16'h0000;
                end else if (st_q == ST_CALC) begin
                    // newest slot holds this frame's value, so the sum spans the last frames
                    hist_q[g] <= (g == 0) ? vrjt_new : hist_q[(g == 0) ? 0 : g - 1];
                end
            end
        end
    endgenerate

    // queue levels mirrored on ports
    always @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            o_q_fixed  <= 16'h0000;
            o_q_var_rt <= 16'h0000;
            o_q_var_jt <= 16'h0000;
            o_q_jt     <= 16'h0000;
        end else begin
            o_q_fixed  <= q_q[`Q_FIXED];
            o_q_var_rt <= q_q[`Q_VAR_RT];
            o_q_var_jt <= q_q[`Q_VAR_JT];
            o_q_jt     <= q_q[`Q_JT];
        end
    end

    // sensitive arrivals counted per frame period
    always @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            rt_arr_q  <= 16'h0000;
            rt_prev_q <= 16'h0000;
        end else if (i_frame_tick) begin
            rt_prev_q <= rt_arr_q;
            rt_arr_q  <= (i_arr_valid && i_arr_class == `Q_VAR_RT) ? {8'h00, i_arr_cells}
                                                                  : 16'h0000;
        end else if (i_arr_valid && i_arr_class == `Q_VAR_RT) begin
            rt_arr_q <= rt_arr_q + {8'h00, i_arr_cells};
        end
    end

    // pending tolerant request: sent volume in, tolerant assignment out
    always @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            pend_jt_q <= 16'h0000;
        end else if (i_frame_tick) begin
            // a volume request taken on the tick edge was still sent: count it
            pend_jt_q <= ((pend_jt_q > take[`Q_JT]) ? pend_jt_q - take[`Q_JT] : 16'h0000)
                         + ((take_cr && st_q == ST_VOL) ? o_cr_value : 16'h0000);
        end else if (take_cr && st_q == ST_VOL) begin
            pend_jt_q <= pend_jt_q + o_cr_value;
        end
    end

    // request sequencer; a new frame tick abandons unused opportunities
    always @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            st_q        <= ST_IDLE;
            opp_q       <= 2'h0;
            vr_req_q    <= 16'h0000;
            send_rate_q <= 1'b0;
            vrem_q      <= 16'h0000;
            last_rate_q <= 16'h0000;
            vrjt_q      <= 16'h0000;
            since_q     <= 8'h00;
            o_cr_kind   <= `KIND_RATE;
            o_cr_value  <= 16'h0000;
        end else if (i_frame_tick) begin
            opp_q   <= i_cr_slots;
            since_q <= (since_q == 8'hFF) ? since_q : since_q + 8'h01;
            st_q    <= ctrl_q[`CTRL_ENABLE] ? ST_CALC : ST_IDLE;
        end else begin
            case (st_q)
                ST_CALC: begin
                    // fixed-rate queue never feeds a request
                    vr_req_q    <= vr_tot;
                    send_rate_q <= (rate_max_q != 16'h0000) &&
                                   ((vr_tot != last_rate_q) ||
                                    (since_q >= {1'b0, timeout_q[7:1]}));
                    vrem_q      <= (jt_sum == 17'h00000) ? 16'h0000 : jt_tot;
                    if (rate_max_q != 16'h0000) begin
                        vrjt_q <= vrjt_c;
                    end
                    o_cr_kind  <= `KIND_RATE;
                    o_cr_value <= vr_tot;
                    st_q       <= ST_RATE;
                end
                ST_RATE, ST_RATE2: begin
                    if (!send_rate_q || opp_q == 2'h0) begin
                        st_q <= ST_VOL;
                        o_cr_kind  <= ctrl_q[`CTRL_ABSOLUTE] ? `KIND_ABS_VOLUME
                                                             : `KIND_VOLUME;
                        o_cr_value <= chunk;
                    end else if (take_cr) begin
                        opp_q       <= opp_q - 2'h1;
                        last_rate_q <= vr_req_q;
                        since_q     <= 8'h00;
                        if (st_q == ST_RATE && ctrl_q[`CTRL_DUP_RATE]) begin
                            st_q <= ST_RATE2;
                        end else begin
                            send_rate_q <= 1'b0;
                        end
                        if (st_q == ST_RATE2) begin
                            send_rate_q <= 1'b0;
                        end
                    end
                end
                ST_VOL: begin
                    if (vrem_q == 16'h0000 || opp_q == 2'h0) begin
                        st_q <= ST_IDLE;
                    end else if (take_cr) begin
                        opp_q  <= opp_q - 2'h1;
                        vrem_q <= vrem_q - chunk;
                        o_cr_value <= ((vrem_q - chunk) > vol_max_q) ? vol_max_q
                                                                     : vrem_q - chunk;
                    end else begin
                        o_cr_value <= chunk;
                    end
                end
                ST_IDLE: begin
                    st_q <= ST_IDLE;
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // avalon-mm slave: acknowledge one cycle after a request arrives
    always @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            ack_q          <= 1'b0;
            o_avs_readdata <= 32'h00000000;
            ctrl_q         <= `RST_CTRL;
            msl_q          <= `RST_MSL;
            rate_max_q     <= `RST_RATE_MAX;
            cra_q          <= `RST_CRA;
            phys_max_q     <= `RST_PHYS_MAX;
            allow_max_q    <= `RST_ALLOW_MAX;
            timeout_q      <= `RST_TIMEOUT;
            vol_max_q      <= `RST_VOL_MAX;
            nm_cells_q     <= `RST_NM_CELLS;
        end else begin
            ack_q <= bus_req & ~ack_q;
            if (bus_req && !ack_q && i_avs_write) begin
                case (i_avs_address[5:2])
                    4'h0: ctrl_q      <= new_word[3:0];
                    4'h1: msl_q       <= new_word[3:0];
                    4'h2: rate_max_q  <= new_word[15:0];
                    4'h3: cra_q       <= new_word[15:0];
                    4'h4: phys_max_q  <= new_word[15:0];
                    4'h5: allow_max_q <= new_word[15:0];
                    4'h6: timeout_q   <= new_word[7:0];
                    4'h7: vol_max_q   <= new_word[15:0];
                    4'h8: nm_cells_q  <= new_word[15:0];
                    default: ctrl_q   <= ctrl_q;    // read-only or unmapped: ignored
                endcase
            end
            // registered read data: costs the wait state, keeps the bus path short
            if (bus_req && !ack_q && i_avs_read) begin
                o_avs_readdata <= reg_word;
            end
        end
    end

endmodule // return_capacity_requester

`default_nettype wire

// File: capreq_checker.sv
// checker of the capacity requester: frame timing, request order, bus answer
// assumes a bind onto return_capacity_requester with one clock domain
`include "capreq_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module capreq_checker (
    input wire logic        I_CLK,             // system clock
    input wire logic        I_RESET_N,         // async reset, active low
    input wire logic        i_avs_read,        // bus read
    input wire logic        i_avs_write,       // bus write
    input wire logic        o_avs_waitrequest, // bus stall
    input wire logic        i_frame_tick,      // frame pulse
    input wire logic [1:0]  i_cr_slots,        // opportunities of frame
    input wire logic        o_cr_valid,        // request offered
    input wire logic [1:0]  o_cr_kind,         // request kind
    input wire logic [15:0] o_cr_value,        // request size
    input wire logic        i_cr_ready,        // request taken
    input wire logic        o_pad_empty        // empty-slot mode
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RESET_N);
    logic [1:0] slots_q, used_q, rate_n_q;
    logic       vol_seen_q;
    // per-frame tally of taken requests, restarted by each frame pulse
    always @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            slots_q <= 2'h0;
            used_q <= 2'h0;
            rate_n_q <= 2'h0;
            vol_seen_q <= 1'b0;
        end else if (i_frame_tick) begin
            slots_q <= i_cr_slots;
            used_q <= 2'h0;
            rate_n_q <= 2'h0;
            vol_seen_q <= 1'b0;
        end else if (o_cr_valid && i_cr_ready) begin
            used_q <= used_q + 2'h1;
            if (o_cr_kind == `KIND_RATE) rate_n_q <= rate_n_q + 2'h1;
            else vol_seen_q <= 1'b1;
        end
    end
    sequence s_bus_req;
        (i_avs_read || i_avs_write) && o_avs_waitrequest;
    endsequence
    sequence s_offer_held;
        o_cr_valid && !i_cr_ready && !i_frame_tick;
    endsequence
    chk_bus_answer: assert property (s_bus_req |=> !o_avs_waitrequest)
        else $error("bus answer late");
    chk_tick_quiet: assert property (i_frame_tick |=> !o_cr_valid)
        else $error("request during calculation");
    chk_slot_limit: assert property (o_cr_valid |-> used_q < slots_q)
        else $error("more requests than opportunities");
    chk_rate_first: assert property (o_cr_valid && vol_seen_q |-> o_cr_kind != `KIND_RATE)
        else $error("rate request after volume");
    chk_rate_twice: assert property (o_cr_valid && o_cr_kind == `KIND_RATE |-> rate_n_q < 2'h2)
        else $error("rate request sent too often");
    chk_offer_holds: assert property (s_offer_held |=> o_cr_valid && $stable(o_cr_value) && $stable(o_cr_kind))
        else $error("offer dropped");
    chk_volume_nonzero: assert property (o_cr_valid && o_cr_kind != `KIND_RATE |-> o_cr_value != 16'h0000)
        else $error("empty volume request");
    chk_kind_legal: assert property (o_cr_valid |-> o_cr_kind != 2'h3)
        else $error("illegal request kind");
    chk_pad_source: assert property ($changed(o_pad_empty) |-> $past(i_avs_write) || $past(i_avs_write, 2))
        else $error("pad mode changed without write");
endmodule // capreq_checker
`default_nettype wire

// File: capreq_sched_model.sv
// scheduler side of the request port: takes offered requests
// assumes the bench drives frame pulses and opportunity counts
`timescale 1ns/1ps
`default_nettype none
module capreq_sched_model (
    input  wire logic clk,      // system clock
    input  wire logic rst_n,    // async reset, active low
    input  wire logic cr_valid, // request offered
    output wire logic cr_ready  // request taken
);
    logic [1:0] phase_q;
    // stall one cycle in three so prompt and slow takes both occur
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) phase_q <= 2'h0;
        else phase_q <= (phase_q == 2'h2) ? 2'h0 : phase_q + 2'h1;
    end
    assign cr_ready = cr_valid && phase_q != 2'h1;
endmodule // capreq_sched_model
`default_nettype wire

// File: tb.sv
// self-checking bench of the capacity requester against a behavioural request model
// assumes capreq_checker and capreq_sched_model compiled alongside the design
`include "capreq_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, tick = 1'b0, av = 1'b0;
    logic [5:0]  adr = 6'h00;
    logic [31:0] wd = 32'h0000_0000, rv;
    logic [15:0] asg = 16'h0000;
    logic [1:0]  sl = 2'h0, acl = 2'h0;
    logic [7:0]  ac = 8'h00;
    wire  [31:0] rdat;
    wire  [15:0] val, qf, qr, qv, qj;
    wire  [1:0]  knd;
    wire         wt, vld, ok, pad;
    integer      errors = 0, check_count = 0, seed = 32'hFF1C, i, pend = 0, last = 0, rtarr = 0;
    integer      rmax = 0, lim = 256, nm = 0, en = 0, dup = 0, ab = 0, since = 0, tmo = 6;
    integer      q[4] = '{0, 0, 0, 0};
    integer      ex[$];
    logic [5:0]  ra[10] = '{`OFS_CTRL, `OFS_MSL, `OFS_RATE_MAX, `OFS_CRA, `OFS_PHYS_MAX,
                            `OFS_TIMEOUT, `OFS_VOL_MAX, `OFS_NM_CELLS, `OFS_STAT_Q01, 6'h3C};
    logic [31:0] rx[10] = '{`RST_CTRL, `RST_MSL, `RST_RATE_MAX, `RST_CRA, `RST_PHYS_MAX,
                            `RST_TIMEOUT, `RST_VOL_MAX, `RST_NM_CELLS, 0, 0};
    return_capacity_requester dut_u (.I_CLK(clk), .I_RESET_N(rst_n), .i_avs_address(adr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_byteenable(4'hF), .i_avs_writedata(wd),
        .o_avs_readdata(rdat), .o_avs_waitrequest(wt), .i_frame_tick(tick),
        .i_assign_cells(asg), .i_cr_slots(sl), .i_arr_valid(av), .i_arr_class(acl),
        .i_arr_cells(ac), .o_cr_valid(vld), .o_cr_kind(knd), .o_cr_value(val),
        .i_cr_ready(ok), .o_pad_empty(pad), .o_q_fixed(qf), .o_q_var_rt(qr),
        .o_q_var_jt(qv), .o_q_jt(qj));
    capreq_sched_model sch_u (.clk(clk), .rst_n(rst_n), .cr_valid(vld), .cr_ready(ok));
    task fail(input string m);
        errors++;
        $display("MISMATCH %0t %s", $time, m);
    endtask
    task cmp_reg(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) fail($sformatf("value %h expected %h", g, e));
    endtask
    task cmp_req(input logic [1:0] k, input logic [15:0] v, input integer e);
        check_count++;
        if ({k, v} !== e[17:0]) fail($sformatf("request %h/%h expected %h", k, v, e));
    endtask
    // avalon master: hold until waitrequest is seen low, take data at that edge
    task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        integer n;
        n = 0;
        adr <= a;
        wr <= w;
        rd <= !w;
        wd <= d;
        do @(posedge clk); while (wt !== 1'b0 && ++n < 50);
        if (n >= 50) fail("bus timeout");
        rv = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask
    // arrivals split into random pieces, one piece per cycle
    task arrive(input logic [1:0] c, input integer n);
        integer p;
        q[c] += n;
        if (c == `Q_VAR_RT) rtarr += n;
        while (n > 0) begin
            p = $unsigned($random(seed)) % 15 + 1;
            if (p > n) p = n;
            av <= 1'b1;
            acl <= c;
            ac <= p[7:0];
            n -= p;
            @(posedge clk);
        end
        av <= 1'b0;
        @(posedge clk);
    endtask
    // one frame: pulse, model of drain and requests, then level checks
    task frame(input logic [15:0] a, input logic [1:0] s);
        integer x, t, r, j, c;
        tick <= 1'b1;
        asg <= a;
        sl <= s;
        x = a;
        for (i = 0; i < 4; i++) begin
            t = (x < q[i]) ? x : q[i];
            q[i] -= t;
            x -= t;
        end
        pend = (pend > t) ? pend - t : 0;
        r = (rtarr > `RST_CRA) ? rtarr - `RST_CRA : 0;
        if (r > rmax) r = rmax;
        if (r > lim - 1) r = lim - 1;
        rtarr = 0;
        since = (since < 255) ? since + 1 : since;
        if (en && s != 0) begin
            if (rmax != 0 && (r != last || since >= tmo / 2)) begin
                ex.push_back(r);
                if (dup) ex.push_back(r);
                last = r;
                since = 0;
            end
            j = ((q[3] > pend) ? q[3] - pend : 0) + nm;
            c = lim - 1 - r - pend;
            if (j > c) j = c;
            pend += j;
            while (j > 0) begin
                c = (j > `RST_VOL_MAX) ? `RST_VOL_MAX : j;
                ex.push_back(((ab ? `KIND_ABS_VOLUME : `KIND_VOLUME) << 16) + c);
                j -= c;
            end
        end
        @(posedge clk);
        tick <= 1'b0;
        repeat (40) @(posedge clk);
        cmp_reg(ex.size(), 0);
        cmp_reg({qr, qf}, {q[1][15:0], q[0][15:0]});
        cmp_reg({qj, qv}, {q[3][15:0], q[2][15:0]});
        ex.delete();
    endtask
    task results;
        $display("errors %0d comparisons %0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // requests compared when taken, sampled where settled
    always @(negedge clk) begin
        if (vld === 1'b1 && ok === 1'b1) begin
            if (ex.size() == 0) fail("unexpected request");
            else cmp_req(knd, val, ex.pop_front());
        end
    end
    initial begin
        forever #20 clk = ~clk;
    end
    // watchdog well beyond the few hundred cycles of the sequence
    initial begin
        repeat (20000) @(posedge clk);
        fail("watchdog");
        results;
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        cmp_reg(pad, 1);
        bus(1'b1, `OFS_STAT_Q01, 32'hFFFF_FFFF);
        for (i = 0; i < 10; i++) begin
            bus(1'b0, ra[i], 32'h0);
            cmp_reg(rv, rx[i]);
        end
        bus(1'b1, `OFS_TIMEOUT, 32'h0000_0006);
        bus(1'b1, `OFS_ALLOW_MAX, 32'h0000_0020);
        bus(1'b1, `OFS_CTRL, 32'h0000_0001);
        lim = 32;
        en = 1;
        cmp_reg(pad, 0);
        arrive(`Q_FIXED, 20);
        arrive(`Q_JT, 100);
        frame(16'h0000, 2'h3);
        bus(1'b1, `OFS_ALLOW_MAX, 32'h0000_0100);
        bus(1'b1, `OFS_RATE_MAX, 32'h0000_0010);
        bus(1'b1, `OFS_NM_CELLS, 32'h0000_0004);
        lim = 256;
        rmax = 16;
        nm = 4;
        arrive(`Q_VAR_RT, 12);
        frame(16'h0000, 2'h3);
        bus(1'b1, `OFS_CTRL, 32'h0000_0005);
        dup = 1;
        arrive(`Q_VAR_RT, 30);
        frame(16'h0000, 2'h3);
        bus(1'b1, `OFS_CTRL, 32'h0000_0003);
        dup = 0;
        cmp_reg(pad, 1);
        arrive(`Q_VAR_RT, 17);
        frame(16'h0064, 2'h3);
        frame(16'h0000, 2'h0);
        bus(1'b1, `OFS_CTRL, 32'h0000_000B);
        ab = 1;
        cmp_reg(pad, 1);
        arrive(`Q_VAR_RT, 17);
        frame(16'h0000, 2'h2);
        results;
    end
endmodule // tb
bind return_capacity_requester capreq_checker chk_u (.I_CLK(I_CLK), .I_RESET_N(I_RESET_N),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest),
    .i_frame_tick(i_frame_tick), .i_cr_slots(i_cr_slots), .o_cr_valid(o_cr_valid),
    .o_cr_kind(o_cr_kind), .o_cr_value(o_cr_value), .i_cr_ready(i_cr_ready),
    .o_pad_empty(o_pad_empty));
`default_nettype wire
